// [rtl/fcde_alu.sv]
// Purpose: Combinational result path for complement and decrement
// Assumes: Operand is the addressed file register value
// Notes:   Zero detect is shared by the flag update and the skip test
`timescale 1ns/1ps
module fcde_alu
  import fcde_pkg::*;
(
  input  wire logic [7:0] operand,
  input  wire logic       doComplement,
  output logic      [7:0] result,
  output logic            resultZero
);
  always_comb
  begin
    if (doComplement)
      result = ~operand;
    else
      result = operand - 8'h01;
    resultZero = (result == 8'h00);
  end
endmodule

// [rtl/fcde_exec.sv]
// Purpose: Decode and execute complement, decrement, decrement-skip-zero
// Assumes: insnValid marks one fetched word per instruction cycle
// Notes:   Fetch stage must drop the prefetched word when flushReg is high
// Notes on behaviour
// - Pattern 0010 01df ffff complements, routes by d, updates zero
// - Destination bit 0 writes working register, 1 writes file register
// - Pattern 0000 11df ffff decrements, routes by d, updates zero
// - Pattern 0010 11df ffff decrements, routes by d, flags untouched
// - Decrement-skip with zero result discards the prefetched word
// - Zero skip runs a no-op cycle, two cycles; nonzero takes one
`timescale 1ns/1ps
module fcde_exec
  import fcde_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        insnValid,
  input  wire logic [11:0] insnWord,
  input  wire logic [7:0]  fileRdData,
  output logic      [4:0]  fileRdAddr,
  output logic      [4:0]  fileWrAddr_reg,
  output logic      [7:0]  fileWrData_reg,
  output logic             fileWrEn_reg,
  output logic      [7:0]  workReg_reg,
  output logic             zeroFlag_reg,
  output logic             flushReg,
  output logic             busyNop_reg
);
  logic [5:0]   opcode;
  logic         isComp;
  logic         isDec;
  logic         isSkip;
  logic         accept;
  logic [7:0]   aluResult;
  logic         aluZero;
  fcde_state_t  state_reg;
  fcde_state_t  state_next;
  logic [4:0]   fileWrAddr_next;
  logic [7:0]   fileWrData_next;
  logic         fileWrEn_next;
  logic [7:0]   workReg_next;
  logic         zeroFlag_next;
  logic         flush_reg;
  logic         flush_next;
  logic         busyNop_next;
  logic         handled;
  logic         fwdHit;
  logic [7:0]   operand;

  // One place decides which opcodes this block owns
  function automatic logic fcdeHandled
  (
    input logic [5:0] op
  );
    return (op == OPC_COMPLEMENT) || (op == OPC_DECREMENT) ||
           (op == OPC_DEC_SKIP);
  endfunction

  function automatic logic [4:0] fileAddrOf
  (
    input logic [11:0] word
  );
    return word[ADDR_W-1:0];
  endfunction

  assign opcode     = insnWord[OPC_MSB:OPC_LSB];
  assign isComp     = (opcode == OPC_COMPLEMENT);
  assign isDec      = (opcode == OPC_DECREMENT);
  assign isSkip     = (opcode == OPC_DEC_SKIP);
  assign handled    = fcdeHandled(opcode);
  // The word after a taken skip is never decoded, even if presented
  assign accept     = insnValid && (state_reg != FCDE_FLUSH);
  assign fileRdAddr = fileAddrOf(insnWord);
  assign flushReg   = flush_reg;

  // The file write lands one edge after our strobe, so the next word on
  // the same address would read the old value; forwarding the pending
  // write keeps back-to-back words on one register correct
  assign fwdHit     = fileWrEn_reg && (fileWrAddr_reg == fileRdAddr);
  assign operand    = fwdHit ? fileWrData_reg : fileRdData;

  fcde_alu uAlu
  (
    .operand      (operand),
    .doComplement (isComp),
    .result       (aluResult),
    .resultZero   (aluZero)
  );

  always_comb
  begin
    state_next      = FCDE_NONE;
    fileWrAddr_next = fileWrAddr_reg;
    fileWrData_next = fileWrData_reg;
    fileWrEn_next   = 1'b0;
    workReg_next    = workReg_reg;
    zeroFlag_next   = zeroFlag_reg;
    flush_next      = 1'b0;
    busyNop_next    = 1'b0;
    case (state_reg)
      FCDE_NONE, FCDE_EXEC:
      begin
        if (accept && handled)
        begin
          state_next = FCDE_EXEC;
          if (insnWord[DEST_BIT] == DEST_WORK)
            workReg_next = aluResult;
          else
          begin
            fileWrEn_next   = 1'b1;
            fileWrAddr_next = fileAddrOf(insnWord);
            fileWrData_next = aluResult;
          end
          // Skip form leaves status alone
          if (!isSkip)
            zeroFlag_next = aluZero;
          if (isSkip && aluZero)
          begin
            state_next   = FCDE_FLUSH;
            flush_next   = 1'b1;
            busyNop_next = 1'b1;
          end
        end
      end
      FCDE_FLUSH:
        state_next = FCDE_NONE;
      default:
        state_next = FCDE_NONE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg      <= FCDE_NONE;
      fileWrAddr_reg <= 5'h00;
      fileWrData_reg <= 8'h00;
      fileWrEn_reg   <= 1'b0;
      workReg_reg    <= WORK_RESET;
      zeroFlag_reg   <= ZERO_RESET;
      flush_reg      <= 1'b0;
      busyNop_reg    <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      fileWrAddr_reg <= fileWrAddr_next;
      fileWrData_reg <= fileWrData_next;
      fileWrEn_reg   <= fileWrEn_next;
      workReg_reg    <= workReg_next;
      zeroFlag_reg   <= zeroFlag_next;
      flush_reg      <= flush_next;
      busyNop_reg    <= busyNop_next;
    end
  end

  AST_COMP_RESULT: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isComp && insnWord[DEST_BIT] |=>
      fileWrEn_reg && fileWrData_reg == ~$past(operand))
    else $error("complement result wrong");
  AST_COMP_WORK: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isComp && !insnWord[DEST_BIT] |=>
      workReg_reg == ~$past(operand))
    else $error("complement to working register wrong");
  AST_DEST_WORK: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && (isComp || isDec) && !insnWord[DEST_BIT] |=>
      !fileWrEn_reg && workReg_reg == $past(aluResult))
    else $error("working register destination wrong");
  AST_DEST_FILE: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && handled && insnWord[DEST_BIT] |=> fileWrEn_reg &&
      fileWrAddr_reg == $past(fileRdAddr) && $stable(workReg_reg))
    else $error("file register destination wrong");
  AST_DEC_RESULT: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isDec && insnWord[DEST_BIT] |=>
      fileWrData_reg == $past(operand) - 8'h01)
    else $error("decrement result wrong");
  AST_DEC_ONE_CYCLE: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isDec |=>
      !flushReg && !busyNop_reg)
    else $error("decrement took more than one cycle");
  AST_SKIP_FLAGS: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isSkip |=>
      $stable(zeroFlag_reg))
    else $error("skip form changed zero flag");
  AST_SKIP_RESULT: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isSkip && !insnWord[DEST_BIT] |=>
      workReg_reg == $past(operand) - 8'h01)
    else $error("skip form result wrong");
  AST_SKIP_FLUSH: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isSkip && operand == 8'h01 |=>
      flushReg ##1 !flushReg && !fileWrEn_reg)
    else $error("zero skip did not flush one word");
  AST_FLUSH_IGNORES: assert property (@(posedge core_clk)
    disable iff (srst)
    flushReg |=>
      !fileWrEn_reg && $stable(workReg_reg))
    else $error("discarded word had an effect");
  AST_NO_SKIP: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && isSkip && operand != 8'h01 |=>
      !busyNop_reg)
    else $error("nonzero skip took two cycles");
  AST_NOP_ONE_CYCLE: assert property (@(posedge core_clk)
    disable iff (srst)
    busyNop_reg |=>
      !busyNop_reg)
    else $error("no-op cycle lasted more than one cycle");
  AST_ZERO_FLAG: assert property (@(posedge core_clk)
    disable iff (srst)
    accept && (isComp || isDec) |=>
      zeroFlag_reg == ($past(aluResult) == 8'h00))
    else $error("zero flag mismatch");

  COV_SKIP_TAKEN: cover property (@(posedge core_clk) disable iff (srst)
    accept && isSkip && aluZero ##1 flushReg);
  COV_COMP_FILE: cover property (@(posedge core_clk) disable iff (srst)
    accept && isComp && insnWord[DEST_BIT]);
  COV_DEC_ZERO: cover property (@(posedge core_clk) disable iff (srst)
    accept && isDec && aluZero);
  COV_FORWARD: cover property (@(posedge core_clk) disable iff (srst)
    accept && handled && fwdHit);
endmodule

// [rtl/fcde_pkg.sv]
// Purpose: Shared constants for the file complement/decrement executor
// Assumes: 12-bit instruction words, 8-bit data, 5-bit file address
// Notes:   Opcode match values cover bits 11:6 of the instruction
package fcde_pkg;
  localparam int          INSN_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 5;
  localparam int          OPC_MSB       = 11;
  localparam int          OPC_LSB       = 6;
  localparam int          DEST_BIT      = 5;
  localparam logic [5:0]  OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0]  OPC_DECREMENT  = 6'h03;
  localparam logic [5:0]  OPC_DEC_SKIP   = 6'h0b;
  localparam logic        DEST_WORK     = 1'h0;
  localparam logic [7:0]  WORK_RESET    = 8'h00;
  localparam logic        ZERO_RESET    = 1'h0;

  typedef enum logic [2:0]
  {
    FCDE_NONE  = 3'h1,
    FCDE_EXEC  = 3'h2,
    FCDE_FLUSH = 3'h4
  } fcde_state_t;
endpackage

// [test/fcde_rf_model.sv]
// Purpose: Register file model on the far side of the executor
// Assumes: Same-cycle read, write on the registered strobe
// Notes:   Bench preloads mem directly through the hierarchy
`timescale 1ns/1ps
module fcde_rf_model
(
  input  wire logic       core_clk,
  input  wire logic [4:0] rdAddr,
  output logic      [7:0] rdData,
  input  wire logic       wrEn,
  input  wire logic [4:0] wrAddr,
  input  wire logic [7:0] wrData
);
  logic [7:0] mem [32];
  assign rdData = mem[rdAddr];
  always @(posedge core_clk)
    if (wrEn)
      mem[wrAddr] <= wrData;
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench for the executor
// Assumes: One word per cycle, driven just after each rising edge
// Notes:   Same-address pairs lean on the executor's write forwarding
`timescale 1ns/1ps
module tb;
  import fcde_pkg::*;
  logic        core_clk = 0, srst = 1, insnValid = 0;
  logic [11:0] insnWord = 12'h000;
  logic [7:0]  fileRdData, workReg_reg, fileWrData_reg, sh [32];
  logic [7:0]  w = WORK_RESET;
  logic [4:0]  fileRdAddr, fileWrAddr_reg;
  logic        fileWrEn_reg, zeroFlag_reg, flushReg, busyNop_reg;
  logic        z = ZERO_RESET, skp = 0;
  logic [23:0] q [$], e, s;
  logic [5:0]  ops [4] = '{OPC_COMPLEMENT, OPC_DECREMENT, OPC_DEC_SKIP,
                           6'h0a};
  int          n_mismatch = 0, num_checks = 0, cyc = 0, i;
  integer      seed = 32'hfbea;
  fcde_exec dut (.core_clk(core_clk), .srst(srst), .insnValid(insnValid),
    .insnWord(insnWord), .fileRdData(fileRdData), .fileRdAddr(fileRdAddr),
    .fileWrAddr_reg(fileWrAddr_reg), .fileWrData_reg(fileWrData_reg),
    .fileWrEn_reg(fileWrEn_reg), .workReg_reg(workReg_reg),
    .zeroFlag_reg(zeroFlag_reg), .flushReg(flushReg),
    .busyNop_reg(busyNop_reg));
  fcde_rf_model rf (.core_clk(core_clk), .rdAddr(fileRdAddr),
    .rdData(fileRdData), .wrEn(fileWrEn_reg), .wrAddr(fileWrAddr_reg),
    .wrData(fileWrData_reg));
  initial forever #50 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [23:0] ex, sn);
    num_checks++;
    if (ex !== sn)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic setf(input logic [4:0] f, input logic [7:0] v);
    sh[f] = v;
    rf.mem[f] = v;
  endtask
  task automatic iss(input logic [11:0] wd);
    logic [7:0] r;
    logic [5:0] op;
    logic       we, fl;
    @(posedge core_clk);
    #1;
    insnValid = 1;
    insnWord  = wd;
    op = wd[11:6];
    r  = (op == OPC_COMPLEMENT) ? ~sh[wd[4:0]] : sh[wd[4:0]] - 8'h01;
    we = 0;
    fl = 0;
    if (!skp && op inside {OPC_COMPLEMENT, OPC_DECREMENT, OPC_DEC_SKIP})
    begin
      we = wd[DEST_BIT];
      if (we)
        sh[wd[4:0]] = r;
      else
        w = r;
      if (op != OPC_DEC_SKIP)
        z = (r == 8'h00);
      fl = (op == OPC_DEC_SKIP) && (r == 8'h00);
    end
    skp = fl;
    q.push_back({we, wd[4:0], r, w, z, fl});
  endtask
  // Sampled before the driver moves, so each note is one edge old
  always @(posedge core_clk)
  begin
    #0.5;
    if (q.size() != 0)
    begin
      e = q.pop_front();
      s = {fileWrEn_reg, fileWrAddr_reg, fileWrData_reg, workReg_reg,
           zeroFlag_reg, flushReg};
      if (!e[23])
        s[22:10] = e[22:10];
      chk("result", e, s);
      chk("noop", {23'h0, e[0]}, {23'h0, busyNop_reg});
    end
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial
  begin
    for (i = 0; i < 32; i++)
      setf(i[4:0], 8'($random(seed)));
    repeat (20) @(posedge core_clk);
    #1 srst = 0;
    chk("reset", 24'h0, {14'h0, workReg_reg, zeroFlag_reg, flushReg});
    setf(5'h05, 8'h13);
    setf(5'h06, 8'h01);
    setf(5'h07, 8'h01);
    setf(5'h08, 8'h03);
    setf(5'h09, 8'h02);
    iss(12'h245);
    iss(12'h0e6);
    iss(12'h2c7);
    iss(12'h245);
    iss(12'h2e8);
    iss(12'h245);
    iss(12'h285);
    iss(12'h0e6);
    iss(12'h0e6);
    iss(12'h2e9);
    iss(12'h2e9);
    $display("test directed done");
    for (i = 0; i < 300; i++)
      iss({ops[$random(seed) & 3], 1'($random(seed)), i[4:0]});
    @(posedge core_clk);
    #1 insnValid = 0;
    repeat (2) @(posedge core_clk);
    $display("test random done");
    print_verdict;
  end
endmodule
